//--- logic/pvic_pkg.sv
// constants for the prioritised vectored interrupt controller
package pvic_pkg;
   localparam int          NUM_SRC        = 32;
   localparam int          PRIO_W         = 3;
   localparam int          STACK_DEPTH    = 8;
   localparam logic [9:0]  OFS_MODE_BASE  = 10'h000;
   localparam logic [9:0]  OFS_VEC_BASE   = 10'h080;
   localparam logic [9:0]  OFS_NORM_VEC   = 10'h100;
   localparam logic [9:0]  OFS_FAST_VEC   = 10'h104;
   localparam logic [9:0]  OFS_CUR_ID     = 10'h108;
   localparam logic [9:0]  OFS_PENDING    = 10'h10c;
   localparam logic [9:0]  OFS_MASK_STAT  = 10'h110;
   localparam logic [9:0]  OFS_CORE_STAT  = 10'h114;
   localparam logic [9:0]  OFS_EN_CMD     = 10'h120;
   localparam logic [9:0]  OFS_DIS_CMD    = 10'h124;
   localparam logic [9:0]  OFS_CLR_CMD    = 10'h128;
   localparam logic [9:0]  OFS_SET_CMD    = 10'h12c;
   localparam logic [9:0]  OFS_EOS_CMD    = 10'h130;
   localparam logic [9:0]  OFS_SPUR_VEC   = 10'h134;
   localparam int          MODE_PRIO_LSB  = 0;
   localparam int          MODE_EDGE_BIT  = 5;
   localparam int          MODE_POL_BIT   = 6;
   localparam logic [31:0] EXT_SRC_MASK   = 32'h3f00_0001;
   localparam logic [31:0] RESET_WORD     = 32'h0000_0000;
endpackage

//--- logic/pvic_top.sv
// prioritised vectored interrupt controller, register port and core request lines
// Operation
// R1: read-only mask image at 0x110, resets to zero, one means enabled
// R2: source bit positions are fixed, bit 0 fast, bit 1 software, etc.
// R3: 0x114 bit 0 shows fast line active, bit 1 normal line active
// R4: write to 0x120 enables sources written with one
// R5: write to 0x124 disables sources written with one
// R6: write to 0x128 clears pending of sources written with one
// R7: write to 0x12c forces pending of sources written with one
// R8: any write to 0x130 ends service of current interrupt
// R9: spurious handler address register at 0x134, read/write, resets zero
// R10: vector read makes highest pending source current, level set to its priority
// R11: vector read drops normal line; software must read it anyway
// R12: vector read auto-clears pending of an edge-triggered selected source
// R13: vector read pushes new level onto level stack
// R14: vector read returns selected source's vector register contents
// R15: during service, normal line reasserts only above current level
// R16: handler removes level-sensitive source condition itself
// R17: end-of-service pops stack, restores previous level or none
// R18: after pop, pending source above restored level reasserts normal line
// R19: handler masks core interrupts then writes end-of-service before return
// R20: core fetches 0x18 and loads pc from the vector read
// R21: vector read with no current interrupt returns zero
// R22: non-fast sources carry priority 0 lowest to 7 highest
// R23: external sources pick level/edge and polarity; internal only level/edge
// R24: equal priority ties go to the lowest source number
// R25: level stack holds eight entries
`timescale 1ns/1ps
`default_nettype none
module pvic_top
(
   // clock, reset, enable
   input  wire logic        I_CLK,
   input  wire logic        I_RESET,
   input  wire logic        I_CE,
   // register port
   input  wire logic [9:0]  I_ADDR,
   input  wire logic [31:0] I_WDATA,
   input  wire logic        I_WR,
   input  wire logic        I_RD,
   output logic      [31:0] O_RDATA,
   // interrupt sources
   input  wire logic [31:0] I_SRC,
   // core request lines, active high
   output logic             O_FAST_REQUEST_LINE,
   output logic             O_NORMAL_REQUEST_LINE
);
   localparam int N  = pvic_pkg::NUM_SRC;
   localparam int PW = pvic_pkg::PRIO_W;
   localparam int SD = pvic_pkg::STACK_DEPTH;

   logic [31:0]   mode_reg [N];
   logic [31:0]   vec_reg  [N];
   logic [31:0]   mask_reg;
   logic [31:0]   pend_reg;
   logic [31:0]   spur_reg;
   logic [31:0]   src_d_reg;
   logic [PW-1:0] stk_reg  [SD];
   logic [4:0]    stk_id_reg [SD];
   logic [3:0]    sp_reg;
   logic [31:0]   rdata_reg;
   logic          fast_reg;
   logic          norm_reg;
   logic          norm_hold_reg;

   logic          wr_hit;
   logic          rd_vec;
   logic          eos;
   logic [31:0]   active;
   logic [31:0]   edge_det;
   logic [31:0]   pend_next;
   logic          cand_ok;
   logic [4:0]    cand_id;
   logic [PW-1:0] cand_pr;
   logic          have_cur;
   logic [PW-1:0] cur_lvl;
   logic [4:0]    cur_id;
   logic          norm_next;

   assign wr_hit   = I_CE && I_WR;
   assign rd_vec   = I_CE && I_RD && (I_ADDR == pvic_pkg::OFS_NORM_VEC);
   assign eos      = wr_hit && (I_ADDR == pvic_pkg::OFS_EOS_CMD);        // [R8]
   assign have_cur = (sp_reg != 4'h0);
   assign cur_lvl  = have_cur ? stk_reg[sp_reg[2:0] - 3'h1] : '0;
   assign cur_id   = have_cur ? stk_id_reg[sp_reg[2:0] - 3'h1] : 5'h00;

   // source sensing: internal sources are fixed active-high
   always_comb
   begin
      for (int i = 0; i < N; i++)
      begin
         logic pol;
         pol = pvic_pkg::EXT_SRC_MASK[i] ? mode_reg[i][pvic_pkg::MODE_POL_BIT] : 1'b1; // [R23]
         active[i]   = (I_SRC[i] == pol);
         edge_det[i] = (I_SRC[i] == pol) && (src_d_reg[i] != pol);
      end
   end

   // highest priority among pending enabled normal sources, lowest number on tie
   always_comb
   begin
      cand_ok = 1'b0;
      cand_id = 5'h00;
      cand_pr = '0;
      for (int i = N - 1; i >= 1; i--)
      begin
         if (pend_reg[i] && mask_reg[i] &&
             (!cand_ok || mode_reg[i][PW-1:0] >= cand_pr))            // [R22] [R24]
         begin
            cand_ok = 1'b1;
            cand_id = 5'(i);
            cand_pr = mode_reg[i][PW-1:0];
         end
      end
   end

   // pending state: hardware set wins over software clear
   always_comb
   begin
      pend_next = pend_reg;
      if (wr_hit && I_ADDR == pvic_pkg::OFS_CLR_CMD)
         pend_next = pend_next & ~I_WDATA;                             // [R6]
      if (rd_vec && cand_ok && mode_reg[cand_id][pvic_pkg::MODE_EDGE_BIT])
         pend_next[cand_id] = 1'b0;                                    // [R12]
      for (int i = 0; i < N; i++)
      begin
         if (mode_reg[i][pvic_pkg::MODE_EDGE_BIT])
         begin
            if (edge_det[i])
               pend_next[i] = 1'b1;
         end
         else
            pend_next[i] = active[i];                                  // [R16]
      end
      if (wr_hit && I_ADDR == pvic_pkg::OFS_SET_CMD)
         pend_next = pend_next | I_WDATA;                              // [R7]
   end

   always_ff @(posedge I_CLK)
   begin
      if (I_RESET)
      begin
         pend_reg  <= pvic_pkg::RESET_WORD;
         src_d_reg <= pvic_pkg::RESET_WORD;
      end
      else if (I_CE)
      begin
         pend_reg  <= pend_next;
         src_d_reg <= I_SRC;
      end
   end

   // mask and spurious address
   always_ff @(posedge I_CLK)
   begin
      if (I_RESET)
      begin
         mask_reg <= pvic_pkg::RESET_WORD;                             // [R1]
         spur_reg <= pvic_pkg::RESET_WORD;                             // [R9]
      end
      else if (wr_hit)
      begin
         if (I_ADDR == pvic_pkg::OFS_EN_CMD)
            mask_reg <= mask_reg | I_WDATA;                            // [R4] [R2]
         if (I_ADDR == pvic_pkg::OFS_DIS_CMD)
            mask_reg <= mask_reg & ~I_WDATA;                           // [R5]
         if (I_ADDR == pvic_pkg::OFS_SPUR_VEC)
            spur_reg <= I_WDATA;                                       // [R9]
      end
   end

   // per-source mode and vector arrays
   always_ff @(posedge I_CLK)
   begin
      if (I_RESET)
      begin
         for (int i = 0; i < N; i++)
         begin
            mode_reg[i] <= pvic_pkg::RESET_WORD;
            vec_reg[i]  <= pvic_pkg::RESET_WORD;
         end
      end
      else if (wr_hit && I_ADDR[9:8] == 2'h0)
      begin
         if (I_ADDR[7] == 1'b0)
            mode_reg[I_ADDR[6:2]] <= {25'h0, I_WDATA[6:5], 2'h0, I_WDATA[PW-1:0]};
         else
            vec_reg[I_ADDR[6:2]] <= I_WDATA;
      end
   end

   // level stack: eight entries cover every priority, so no overflow in normal use
   always_ff @(posedge I_CLK)
   begin
      if (I_RESET)
      begin
         sp_reg <= 4'h0;
         for (int i = 0; i < SD; i++)
         begin
            stk_reg[i]    <= '0;
            stk_id_reg[i] <= 5'h00;
         end
      end
      else if (I_CE)
      begin
         if (rd_vec && cand_ok && sp_reg != 4'(SD))
         begin
            stk_reg[sp_reg[2:0]]    <= cand_pr;                        // [R10] [R13] [R25]
            stk_id_reg[sp_reg[2:0]] <= cand_id;
            sp_reg                  <= sp_reg + 4'h1;
         end
         else if (eos && have_cur)
            sp_reg <= sp_reg - 4'h1;                                   // [R17]
      end
   end

   // normal line: raised for a source above the current level
   // held low by vector read and end of service, so a stale level is never judged
   always_comb
   begin
      norm_next = cand_ok && (!have_cur || cand_pr > cur_lvl);         // [R15] [R18]
      if (rd_vec || eos || norm_hold_reg)
         norm_next = 1'b0;                                             // [R11]
   end

   // one cycle of hold lets the stack update before the line is judged again
   always_ff @(posedge I_CLK)
   begin
      if (I_RESET)
      begin
         norm_reg      <= 1'b0;
         norm_hold_reg <= 1'b0;
         fast_reg      <= 1'b0;
      end
      else if (I_CE)
      begin
         norm_hold_reg <= rd_vec || eos;
         norm_reg      <= norm_next;
         fast_reg      <= pend_next[0] && mask_reg[0];
      end
   end

   // read data, valid the cycle after the strobe
   always_ff @(posedge I_CLK)
   begin
      if (I_RESET)
         rdata_reg <= pvic_pkg::RESET_WORD;
      else if (I_CE)
      begin
         rdata_reg <= pvic_pkg::RESET_WORD;
         if (I_RD)
         begin
            if (I_ADDR[9:8] == 2'h0)
               rdata_reg <= I_ADDR[7] ? vec_reg[I_ADDR[6:2]] : mode_reg[I_ADDR[6:2]];
            else
            begin
               case (I_ADDR)
                  pvic_pkg::OFS_NORM_VEC:
                     rdata_reg <= cand_ok ? vec_reg[cand_id] : pvic_pkg::RESET_WORD; // [R14] [R21] [R20]
                  pvic_pkg::OFS_FAST_VEC:  rdata_reg <= vec_reg[0];
                  pvic_pkg::OFS_CUR_ID:    rdata_reg <= {27'h0, cur_id};
                  pvic_pkg::OFS_PENDING:   rdata_reg <= pend_reg;
                  pvic_pkg::OFS_MASK_STAT: rdata_reg <= mask_reg;                    // [R1]
                  pvic_pkg::OFS_CORE_STAT: rdata_reg <= {30'h0, norm_reg, fast_reg}; // [R3]
                  pvic_pkg::OFS_SPUR_VEC:  rdata_reg <= spur_reg;
                  default:                 rdata_reg <= pvic_pkg::RESET_WORD;
               endcase
            end
         end
      end
   end

   // handler must mask core interrupts before the end-of-service write [R19]
   assign O_RDATA               = rdata_reg;
   assign O_FAST_REQUEST_LINE   = fast_reg;
   assign O_NORMAL_REQUEST_LINE = norm_reg;
endmodule
`default_nettype wire

//--- testbench/pvic_props.sv
// assertions on the controller ports
`timescale 1ns/1ps
`default_nettype none
module pvic_props
(
   // clock, reset, enable
   input wire logic        I_CLK,
   input wire logic        I_RESET,
   input wire logic        I_CE,
   // register port
   input wire logic [9:0]  I_ADDR,
   input wire logic [31:0] I_WDATA,
   input wire logic        I_WR,
   input wire logic        I_RD,
   input wire logic [31:0] O_RDATA,
   // sources and lines
   input wire logic [31:0] I_SRC,
   input wire logic        O_FAST_REQUEST_LINE,
   input wire logic        O_NORMAL_REQUEST_LINE
);
   default clocking @(posedge I_CLK); endclocking
   default disable iff (I_RESET);
   logic        wr;
   logic        rd;
   logic [31:0] mask_reg;
   logic [31:0] spur_reg;
   assign wr = I_CE && I_WR;
   assign rd = I_CE && I_RD;
   always_ff @(posedge I_CLK)
   begin
      if (I_RESET)
         mask_reg <= 32'h0;
      else if (wr && I_ADDR == pvic_pkg::OFS_EN_CMD)
         mask_reg <= mask_reg | I_WDATA;
      else if (wr && I_ADDR == pvic_pkg::OFS_DIS_CMD)
         mask_reg <= mask_reg & ~I_WDATA;
   end
   always_ff @(posedge I_CLK)
   begin
      if (I_RESET)
         spur_reg <= 32'h0;
      else if (wr && I_ADDR == pvic_pkg::OFS_SPUR_VEC)
         spur_reg <= I_WDATA;
   end
   property p_mask;
      rd && I_ADDR == pvic_pkg::OFS_MASK_STAT |=> O_RDATA == $past(mask_reg);
   endproperty
   a_mask: assert property (p_mask) else $error("mask image wrong");
   property p_spur;
      rd && I_ADDR == pvic_pkg::OFS_SPUR_VEC |=> O_RDATA == $past(spur_reg);
   endproperty
   a_spur: assert property (p_spur) else $error("spurious vector wrong");
   property p_core;
      rd && I_ADDR == pvic_pkg::OFS_CORE_STAT |=>
         O_RDATA == {30'h0, $past(O_NORMAL_REQUEST_LINE), $past(O_FAST_REQUEST_LINE)};
   endproperty
   a_core: assert property (p_core) else $error("line status wrong");
   property p_nrm_drop;
      rd && I_ADDR == pvic_pkg::OFS_NORM_VEC |=> !O_NORMAL_REQUEST_LINE ##1 !O_NORMAL_REQUEST_LINE;
   endproperty
   a_nrm_drop: assert property (p_nrm_drop) else $error("line kept after vector");
   property p_eos_drop;
      wr && I_ADDR == pvic_pkg::OFS_EOS_CMD |=> !O_NORMAL_REQUEST_LINE [*2];
   endproperty
   a_eos_drop: assert property (p_eos_drop) else $error("line kept after end");
   property p_fast_dis;
      wr && I_ADDR == pvic_pkg::OFS_DIS_CMD && I_WDATA[0] |-> ##2 !O_FAST_REQUEST_LINE;
   endproperty
   a_fast_dis: assert property (p_fast_dis) else $error("fast line kept");
   property p_rd_alone;
      !$past(rd) && !rd |=> O_RDATA == 32'h0;
   endproperty
   a_rd_alone: assert property (p_rd_alone) else $error("stray read data");
   // a frozen enable must not let the lines move
   property p_freeze;
      !I_CE |=> $stable(O_NORMAL_REQUEST_LINE) && $stable(O_FAST_REQUEST_LINE);
   endproperty
   a_freeze: assert property (p_freeze) else $error("lines moved while frozen");
endmodule
bind pvic_top pvic_props u_props (.I_CLK(I_CLK), .I_RESET(I_RESET), .I_CE(I_CE),
   .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA),
   .I_SRC(I_SRC), .O_FAST_REQUEST_LINE(O_FAST_REQUEST_LINE),
   .O_NORMAL_REQUEST_LINE(O_NORMAL_REQUEST_LINE));
`default_nettype wire

//--- testbench/pvic_core_model.sv
// core side: takes the normal line while unmasked
`timescale 1ns/1ps
`default_nettype none
module pvic_core_model
(
   // clock, reset, lines
   input  wire logic i_clk,
   input  wire logic i_rst,
   input  wire logic i_normal,
   input  wire logic i_unmask,
   output logic      o_take
);
   logic masked_reg;
   // entry jumps through the vector read
   assign o_take = i_normal && !masked_reg;
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         masked_reg <= 1'b0;
      else if (o_take)
         masked_reg <= 1'b1;
      else if (i_unmask)
         masked_reg <= 1'b0;
   end
endmodule
`default_nettype wire

//--- testbench/tb.sv
// self-checking bench for the interrupt controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin failures++; \
   $display("wrong value %0t %h", $time, a); end end
module tb;
   logic        clk, rst, ce, wr, rd, fast, normal, take, unmask;
   logic [9:0]  addr;
   logic [31:0] wdata, rdata, src, d, r, v2, v3, v4;
   int          failures, tests_run, cyc;
   logic [9:0]  ra [5] = '{pvic_pkg::OFS_MASK_STAT, pvic_pkg::OFS_CORE_STAT,
      pvic_pkg::OFS_SPUR_VEC, pvic_pkg::OFS_NORM_VEC, 10'h118};
   pvic_top uut (.I_CLK(clk), .I_RESET(rst), .I_CE(ce), .I_ADDR(addr), .I_WDATA(wdata),
      .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_SRC(src),
      .O_FAST_REQUEST_LINE(fast), .O_NORMAL_REQUEST_LINE(normal));
   pvic_core_model core (.i_clk(clk), .i_rst(rst), .i_normal(normal), .i_unmask(unmask),
      .o_take(take));
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 4000)
      begin
         failures++;
         report_and_stop();
      end
   end
   function automatic logic [31:0] edge_mode(input logic [2:0] p);
      return (32'h1 << pvic_pkg::MODE_EDGE_BIT) | {29'h0, p};
   endfunction
   task automatic wr_reg(input logic [9:0] a, input logic [31:0] v);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= v;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [9:0] a);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask
   task automatic cfg(input int s, input logic [2:0] p, input logic [31:0] v);
      wr_reg(pvic_pkg::OFS_MODE_BASE + 10'(4 * s), edge_mode(p));
      wr_reg(pvic_pkg::OFS_VEC_BASE + 10'(4 * s), v);
   endtask
   task automatic wait_take();
      #1;
      repeat (40)
         if (take !== 1'b1)
            @(posedge clk) #1;
      `CHK(take, 1'b1)
   endtask
   // the handler reads the vector, then lets the core take nested requests
   task automatic take_vec();
      rd_reg(pvic_pkg::OFS_NORM_VEC);
      @(posedge clk);
      unmask <= 1'b1;
      @(posedge clk);
      unmask <= 1'b0;
   endtask
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   initial
   begin
      {rst, wr, rd, addr, wdata, unmask} = '0;
      ce = 1'b1;
      rst = 1'b1;
      // low-level external inputs idle high so nothing pends by accident
      src = pvic_pkg::EXT_SRC_MASK;
      void'($urandom(21945));
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      foreach (ra[i])
      begin
         rd_reg(ra[i]);
         `CHK(d, 32'h0)
      end
      $display("test reset done");
      r = $urandom;
      wr_reg(pvic_pkg::OFS_SPUR_VEC, r);
      ce <= 1'b0;
      wr_reg(pvic_pkg::OFS_SPUR_VEC, ~r);
      ce <= 1'b1;
      rd_reg(pvic_pkg::OFS_SPUR_VEC);
      `CHK(d, r)
      $display("test spurious done");
      r = $urandom;
      v2 = $urandom;
      wr_reg(pvic_pkg::OFS_EN_CMD, r);
      wr_reg(pvic_pkg::OFS_DIS_CMD, v2);
      rd_reg(pvic_pkg::OFS_MASK_STAT);
      `CHK(d, r & ~v2)
      wr_reg(pvic_pkg::OFS_DIS_CMD, 32'hffff_ffff);
      $display("test mask done");
      v2 = $urandom;
      v3 = $urandom;
      v4 = $urandom;
      cfg(2, 3'h5, v2);
      cfg(3, 3'h5, v3);
      cfg(4, 3'h6, v4);
      wr_reg(pvic_pkg::OFS_EN_CMD, 32'h0000_001c);
      wr_reg(pvic_pkg::OFS_SET_CMD, 32'h0000_000c);
      wait_take();
      rd_reg(pvic_pkg::OFS_CORE_STAT);
      `CHK(d, 32'h2)
      take_vec();
      `CHK(d, v2)
      rd_reg(pvic_pkg::OFS_PENDING);
      `CHK(d, 32'h8)
      wr_reg(pvic_pkg::OFS_SET_CMD, 32'h0000_0010);
      wait_take();
      take_vec();
      `CHK(d, v4)
      wr_reg(pvic_pkg::OFS_EOS_CMD, $urandom);
      repeat (6) @(posedge clk);
      #1;
      `CHK(normal, 1'b0)
      wr_reg(pvic_pkg::OFS_EOS_CMD, $urandom);
      wait_take();
      take_vec();
      `CHK(d, v3)
      wr_reg(pvic_pkg::OFS_EOS_CMD, $urandom);
      $display("test nesting done");
      // fast source idles high as a low-level input; pulling it low raises the fast line
      wr_reg(pvic_pkg::OFS_EN_CMD, 32'h0000_0001);
      src[0] <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      `CHK(fast, 1'b1)
      rd_reg(pvic_pkg::OFS_CORE_STAT);
      `CHK(d, 32'h1)
      wr_reg(pvic_pkg::OFS_DIS_CMD, 32'h0000_0001);
      @(posedge clk) #1;
      `CHK(fast, 1'b0)
      $display("test fast done");
      // a level source beside a falling-edge external source driven from the pins
      v2 = $urandom;
      v3 = $urandom;
      wr_reg(pvic_pkg::OFS_MODE_BASE + 10'h014, 32'h0000_0002);
      wr_reg(pvic_pkg::OFS_VEC_BASE + 10'h014, v2);
      cfg(24, 3'h1, v3);
      wr_reg(pvic_pkg::OFS_EN_CMD, 32'h0100_0020);
      src[0] <= 1'b1;
      src[5] <= 1'b1;
      src[24] <= 1'b0;
      wait_take();
      take_vec();
      `CHK(d, v2)
      rd_reg(pvic_pkg::OFS_PENDING);
      `CHK(d, 32'h0100_0020)
      @(posedge clk);
      src[5] <= 1'b0;
      wr_reg(pvic_pkg::OFS_EOS_CMD, $urandom);
      wait_take();
      take_vec();
      `CHK(d, v3)
      rd_reg(pvic_pkg::OFS_PENDING);
      `CHK(d, 32'h0)
      wr_reg(pvic_pkg::OFS_EOS_CMD, $urandom);
      src[24] <= 1'b1;
      $display("test pin sources done");
      wr_reg(pvic_pkg::OFS_DIS_CMD, 32'h0000_001c);
      wr_reg(pvic_pkg::OFS_SET_CMD, 32'h0000_0004);
      wr_reg(pvic_pkg::OFS_CLR_CMD, 32'h0000_0004);
      rd_reg(pvic_pkg::OFS_PENDING);
      `CHK(d, 32'h0)
      rd_reg(pvic_pkg::OFS_NORM_VEC);
      `CHK(d, 32'h0)
      $display("test clear done");
      report_and_stop();
   end
endmodule
`default_nettype wire
